//--- common/cpg_pkg.sv
// constants for the complementary pulse-width generator
package cpg_pkg;
    localparam int CPG_CNT_W = 16;
    localparam int CPG_DIV_W = 3;
    localparam int CPG_PRE_W = 7;
    // register byte offsets
    localparam logic [7:0] CPG_TBCON_OFF = 8'h00;
    localparam logic [7:0] CPG_TBDIV_OFF = 8'h04;
    localparam logic [7:0] CPG_MPER_OFF = 8'h08;
    localparam logic [7:0] CPG_MDUTY_OFF = 8'h0C;
    localparam logic [7:0] CPG_GCON_OFF = 8'h10;
    localparam logic [7:0] CPG_OCON_OFF = 8'h14;
    localparam logic [7:0] CPG_DUTY_OFF = 8'h18;
    localparam logic [7:0] CPG_PHASE_OFF = 8'h1C;
    localparam logic [7:0] CPG_DT_OFF = 8'h20;
    localparam logic [7:0] CPG_ALTDT_OFF = 8'h24;
    localparam logic [7:0] CPG_STAT_OFF = 8'h28;
    // field positions
    localparam int CPG_EN_BIT = 15;
    localparam int CPG_DIV_LSB = 0;
    localparam int CPG_IMM_BIT = 0;
    localparam int CPG_CRM_BIT = 1;
    localparam int CPG_CTR_BIT = 2;
    localparam int CPG_MDSEL_BIT = 8;
    localparam int CPG_ITB_BIT = 9;
    localparam int CPG_OVERRIDE_SYNC_SELECT_BIT = 0;
    localparam int CPG_OVAL_LSB = 6;
    localparam int CPG_OVEN_LSB = 8;
    localparam int CPG_MODE_LSB = 10;
    localparam int CPG_STAT_OUT_LSB = 16;
    // output modes
    localparam logic [1:0] CPG_MODE_COMP = 2'h0;
    localparam logic [1:0] CPG_MODE_PUSH = 2'h1;
    localparam logic [1:0] CPG_MODE_REDUN = 2'h2;
    localparam logic [1:0] CPG_MODE_INDEP = 2'h3;
    // highest divider code; 111 acts as 110
    localparam logic [2:0] CPG_DIV_MAX = 3'h6;
    // reset values
    localparam logic [15:0] CPG_PER_RST = 16'hFFFF;
    localparam logic [15:0] CPG_ZERO_RST = 16'h0000;
    // override pair order {high, low}
    localparam int CPG_OV_H = 1;
    localparam int CPG_OV_L = 0;
endpackage

//--- common/cpg_dt_if.sv
// carrier between the generator core and the dead-time stage
`timescale 1ns/1ps
interface cpg_dt_if #(parameter int CW = 16);
    logic tick;
    logic comp;
    logic ovr_both;
    logic want_h;
    logic want_l;
    logic [CW-1:0] rise_dt;
    logic [CW-1:0] fall_dt;
    logic out_h;
    logic out_l;
    modport gen (output tick, comp, ovr_both, want_h, want_l, rise_dt, fall_dt,
        input out_h, out_l);
    modport dts (input tick, comp, ovr_both, want_h, want_l, rise_dt, fall_dt,
        output out_h, out_l);
endinterface

//--- verilog/cpg_deadtime.sv
// dead-time stage driving the high and low side outputs
`timescale 1ns/1ps
module cpg_deadtime import cpg_pkg::*; #(
    parameter int CW = CPG_CNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    cpg_dt_if.dts dt
);
    logic out_h_ff;
    logic out_l_ff;
    logic [CW-1:0] dt_cnt_ff;
    logic h_off;
    logic l_off;

    assign h_off = out_h_ff & ~dt.want_h;
    assign l_off = out_l_ff & ~dt.want_l;
    assign dt.out_h = out_h_ff;
    assign dt.out_l = out_l_ff;

    // a turn-off is immediate; a turn-on waits out the dead time, so every
    // edge source (duty write, phase change, override release) gets the gap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_h_ff <= 1'b0;
            out_l_ff <= 1'b0;
            dt_cnt_ff <= '0;
        end else if (!dt.comp || dt.ovr_both) begin
            // full override or non-complementary: pins follow request directly
            out_h_ff <= dt.want_h;
            out_l_ff <= dt.want_l;
            dt_cnt_ff <= '0;
        end else if (h_off || l_off) begin
            out_h_ff <= out_h_ff & dt.want_h;
            out_l_ff <= out_l_ff & dt.want_l;
            dt_cnt_ff <= h_off ? dt.fall_dt : dt.rise_dt;
        end else if (dt_cnt_ff != '0) begin
            if (dt.tick) begin
                dt_cnt_ff <= dt_cnt_ff - 1'b1;
            end
        end else if (dt.want_h && !out_l_ff) begin
            out_h_ff <= 1'b1;
        end else if (dt.want_l && !out_h_ff) begin
            out_l_ff <= 1'b1;
        end
    end
endmodule

//--- verilog/cpg_pwm_top.sv
// complementary pwm generator with ahb-lite register access
`timescale 1ns/1ps
module cpg_pwm_top import cpg_pkg::*; #(
    parameter int CW = CPG_CNT_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cur_reset_in,
    output logic high_side_out,
    output logic low_side_out
);
    // bus
    logic [7:0] addr_ff;
    logic wr_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_val;
    logic acc;
    // software registers
    logic en_ff;
    logic [2:0] div_ff;
    logic [CW-1:0] mper_ff;
    logic [CW-1:0] mdc_ff;
    logic imm_ff;
    logic crm_ff;
    logic ctr_ff;
    logic mdsel_ff;
    logic itb_ff;
    logic override_sync_select_ff;
    logic [1:0] oval_ff;
    logic [1:0] oven_ff;
    logic [1:0] mode_ff;
    logic [CW-1:0] pdc_ff;
    logic [CW-1:0] phase_ff;
    logic [CW-1:0] dtr_ff;
    logic [CW-1:0] altdtr_ff;
    // engine
    logic [CPG_PRE_W-1:0] pre_ff;
    logic [2:0] div_eff;
    logic tick;
    logic [CW-1:0] mcnt_ff;
    logic mup_ff;
    logic [CW-1:0] lcnt_ff;
    logic lup_ff;
    logic [CW:0] mstep;
    logic [CW:0] lstep;
    logic [CW-1:0] cnt;
    logic [CW-1:0] per;
    logic bnd;
    logic cr_q_ff;
    logic cr_evt;
    logic [CW-1:0] duty_src;
    logic [CW-1:0] act_duty_ff;
    logic raw;
    logic alt_ff;
    logic gen_h;
    logic gen_l;
    logic [1:0] oven_act_ff;
    logic [1:0] oval_act_ff;

    cpg_dt_if #(.CW(CW)) dti ();

    function automatic logic [CW:0] tb_step(input logic [CW-1:0] c, input logic up,
        input logic [CW-1:0] p, input logic ctr);
        logic [CW:0] nx;
        nx = {1'b1, c};
        if (!ctr) begin
            nx = (c >= p) ? {1'b1, {CW{1'b0}}} : {1'b1, c + 1'b1};
        end else if (up) begin
            if (c >= p) begin
                nx = {1'b0, (p == '0) ? c : c - 1'b1};
            end else begin
                nx = {1'b1, c + 1'b1};
            end
        end else if (c == '0) begin
            nx = {1'b1, (p == '0) ? c : c + 1'b1};
        end else begin
            nx = {1'b0, c - 1'b1};
        end
        return nx;
    endfunction

    // period boundary: top of the ramp, or bottom of the triangle
    function automatic logic tb_bnd(input logic [CW-1:0] c, input logic up,
        input logic [CW-1:0] p, input logic ctr);
        return ctr ? (!up && c == '0) : (c >= p);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ---------------- ahb-lite slave ----------------
    // zero wait state, always okay; unmapped reads give zero
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign acc = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 8'h00;
            wr_ff <= 1'b0;
        end else begin
            addr_ff <= acc ? haddr[7:0] : addr_ff;
            wr_ff <= acc && hwrite;
        end
    end

    always_comb begin
        rd_val = 32'h00000000;
        unique case (haddr[7:0])
            CPG_TBCON_OFF: rd_val[CPG_EN_BIT] = en_ff;
            CPG_TBDIV_OFF: rd_val[CPG_DIV_LSB +: CPG_DIV_W] = div_ff;
            CPG_MPER_OFF: rd_val[CW-1:0] = mper_ff;
            CPG_MDUTY_OFF: rd_val[CW-1:0] = mdc_ff;
            CPG_GCON_OFF: begin
                rd_val[CPG_IMM_BIT] = imm_ff;
                rd_val[CPG_CRM_BIT] = crm_ff;
                rd_val[CPG_CTR_BIT] = ctr_ff;
                rd_val[CPG_MDSEL_BIT] = mdsel_ff;
                rd_val[CPG_ITB_BIT] = itb_ff;
            end
            CPG_OCON_OFF: begin
                rd_val[CPG_OVERRIDE_SYNC_SELECT_BIT] = override_sync_select_ff;
                rd_val[CPG_OVAL_LSB +: 2] = oval_ff;
                rd_val[CPG_OVEN_LSB +: 2] = oven_ff;
                rd_val[CPG_MODE_LSB +: 2] = mode_ff;
            end
            CPG_DUTY_OFF: rd_val[CW-1:0] = pdc_ff;
            CPG_PHASE_OFF: rd_val[CW-1:0] = phase_ff;
            CPG_DT_OFF: rd_val[CW-1:0] = dtr_ff;
            CPG_ALTDT_OFF: rd_val[CW-1:0] = altdtr_ff;
            CPG_STAT_OFF: begin
                rd_val[CW-1:0] = cnt;
                rd_val[CPG_STAT_OUT_LSB] = dti.out_h;
                rd_val[CPG_STAT_OUT_LSB+1] = dti.out_l;
            end
            default: rd_val = 32'h00000000;
        endcase
    end

    // read data is sampled in the address phase, so a read right after a
    // write to the same register returns the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (acc && !hwrite) begin
            hrdata_ff <= rd_val;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ff <= 1'b0;
            div_ff <= 3'h0;
            mper_ff <= CPG_PER_RST[CW-1:0];
            mdc_ff <= CPG_ZERO_RST[CW-1:0];
            pdc_ff <= CPG_ZERO_RST[CW-1:0];
            phase_ff <= CPG_PER_RST[CW-1:0];
            dtr_ff <= CPG_ZERO_RST[CW-1:0];
            altdtr_ff <= CPG_ZERO_RST[CW-1:0];
        end else if (wr_ff) begin
            if (hit(addr_ff, CPG_TBCON_OFF)) en_ff <= hwdata[CPG_EN_BIT];
            if (hit(addr_ff, CPG_TBDIV_OFF)) div_ff <= hwdata[CPG_DIV_LSB +: CPG_DIV_W];
            if (hit(addr_ff, CPG_MPER_OFF)) mper_ff <= hwdata[CW-1:0];
            if (hit(addr_ff, CPG_MDUTY_OFF)) mdc_ff <= hwdata[CW-1:0];
            if (hit(addr_ff, CPG_DUTY_OFF)) pdc_ff <= hwdata[CW-1:0];
            if (hit(addr_ff, CPG_PHASE_OFF)) phase_ff <= hwdata[CW-1:0];
            if (hit(addr_ff, CPG_DT_OFF)) dtr_ff <= hwdata[CW-1:0];
            if (hit(addr_ff, CPG_ALTDT_OFF)) altdtr_ff <= hwdata[CW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imm_ff <= 1'b0;
            crm_ff <= 1'b0;
            ctr_ff <= 1'b0;
            mdsel_ff <= 1'b0;
            itb_ff <= 1'b0;
        end else if (wr_ff && hit(addr_ff, CPG_GCON_OFF)) begin
            imm_ff <= hwdata[CPG_IMM_BIT];
            crm_ff <= hwdata[CPG_CRM_BIT];
            ctr_ff <= hwdata[CPG_CTR_BIT];
            mdsel_ff <= hwdata[CPG_MDSEL_BIT];
            itb_ff <= hwdata[CPG_ITB_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            override_sync_select_ff <= 1'b0;
            oval_ff <= 2'h0;
            oven_ff <= 2'h0;
            mode_ff <= CPG_MODE_COMP;
        end else if (wr_ff && hit(addr_ff, CPG_OCON_OFF)) begin
            override_sync_select_ff <= hwdata[CPG_OVERRIDE_SYNC_SELECT_BIT];
            oval_ff <= hwdata[CPG_OVAL_LSB +: 2];
            oven_ff <= hwdata[CPG_OVEN_LSB +: 2];
            mode_ff <= hwdata[CPG_MODE_LSB +: 2];
        end
    end

    // ---------------- clock divider ----------------
    assign div_eff = (div_ff > CPG_DIV_MAX) ? CPG_DIV_MAX : div_ff;
    assign tick = en_ff && (pre_ff >= ((CPG_PRE_W'(1) << div_eff) - 1'b1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_ff <= '0;
        end else if (!en_ff || tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    // ---------------- time bases ----------------
    assign mstep = tb_step(mcnt_ff, mup_ff, mper_ff, ctr_ff);
    assign lstep = tb_step(lcnt_ff, lup_ff, phase_ff, ctr_ff);
    assign cnt = itb_ff ? lcnt_ff : mcnt_ff;
    assign per = itb_ff ? phase_ff : mper_ff;
    assign bnd = tick && (itb_ff ? tb_bnd(lcnt_ff, lup_ff, phase_ff, ctr_ff)
        : tb_bnd(mcnt_ff, mup_ff, mper_ff, ctr_ff));
    // edge detect: any pulse width restarts once per rising edge
    assign cr_evt = en_ff && crm_ff && cur_reset_in && !cr_q_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cr_q_ff <= 1'b0;
        end else begin
            cr_q_ff <= cur_reset_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mcnt_ff <= '0;
            mup_ff <= 1'b1;
        end else if (!en_ff || (cr_evt && !itb_ff)) begin
            mcnt_ff <= '0;
            mup_ff <= 1'b1;
        end else if (tick) begin
            mcnt_ff <= mstep[CW-1:0];
            mup_ff <= mstep[CW];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lcnt_ff <= '0;
            lup_ff <= 1'b1;
        end else if (!en_ff || (cr_evt && itb_ff)) begin
            lcnt_ff <= '0;
            lup_ff <= 1'b1;
        end else if (tick) begin
            lcnt_ff <= lstep[CW-1:0];
            lup_ff <= lstep[CW];
        end
    end

    // ---------------- duty ----------------
    assign duty_src = mdsel_ff ? mdc_ff : pdc_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_duty_ff <= '0;
        end else if (!en_ff || imm_ff || bnd) begin
            act_duty_ff <= duty_src;
        end
    end

    // duty at or past the period is full on, zero is full off
    assign raw = en_ff && (act_duty_ff != '0) &&
        ((act_duty_ff >= per) || (cnt < act_duty_ff));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alt_ff <= 1'b0;
        end else if (!en_ff) begin
            alt_ff <= 1'b0;
        end else if (bnd) begin
            alt_ff <= ~alt_ff;
        end
    end

    always_comb begin
        gen_h = 1'b0;
        gen_l = 1'b0;
        unique case (mode_ff)
            CPG_MODE_COMP: begin
                gen_h = raw;
                gen_l = en_ff && !raw;
            end
            CPG_MODE_PUSH: begin
                gen_h = raw && !alt_ff;
                gen_l = raw && alt_ff;
            end
            CPG_MODE_REDUN: begin
                gen_h = raw;
                gen_l = raw;
            end
            CPG_MODE_INDEP: begin
                gen_h = raw;
                gen_l = en_ff && !raw;
            end
        endcase
    end

    // ---------------- overrides ----------------
    // with sync at the boundary the override waits for the period end;
    // while stopped there is no boundary, so it is taken at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oven_act_ff <= 2'h0;
            oval_act_ff <= 2'h0;
        end else if (!override_sync_select_ff || !en_ff || bnd) begin
            oven_act_ff <= oven_ff;
            oval_act_ff <= oval_ff;
        end
    end

    assign dti.tick = tick;
    assign dti.comp = (mode_ff == CPG_MODE_COMP);
    assign dti.ovr_both = &oven_act_ff;
    assign dti.want_h = oven_act_ff[CPG_OV_H] ? oval_act_ff[CPG_OV_H] : gen_h;
    assign dti.want_l = oven_act_ff[CPG_OV_L] ? oval_act_ff[CPG_OV_L] : gen_l;
    assign dti.rise_dt = dtr_ff;
    assign dti.fall_dt = altdtr_ff;

    cpg_deadtime #(.CW(CW)) u_dt (
        .hclk(hclk),
        .hresetn(hresetn),
        .dt(dti.dts)
    );

    assign high_side_out = dti.out_h;
    assign low_side_out = dti.out_l;
endmodule

//--- testbench/cpg_stage_model.sv
// current-sense comparator of the power stage
`timescale 1ns/1ps
module cpg_stage_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fire,
    output logic cur_reset_in
);
    // one 10 ns pulse per request; the restart is edge detected, so any width restarts once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_reset_in <= 1'b0;
        end else begin
            cur_reset_in <= fire && !cur_reset_in;
        end
    end
endmodule

//--- testbench/cpg_pwm_checker.sv
// port assertions for the pwm generator
`timescale 1ns/1ps
module cpg_pwm_checker import cpg_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic cur_reset_in,
    input wire logic high_side_out,
    input wire logic low_side_out
);
    logic ap_wr_ff;
    logic ap_rd_ff;
    logic [7:0] ap_off_ff;
    logic [31:0] tbcon_ff;
    logic [31:0] ocon_ff;
    logic [1:0] still_ff;
    logic [15:0] rdt_ff;
    logic [15:0] fdt_ff;
    logic [15:0] gap_ff;
    logic ov_both;
    logic quiet;
    assign ov_both = ocon_ff[CPG_OVEN_LSB+1] && ocon_ff[CPG_OVEN_LSB];
    // outputs lag a control write, so judge only after two settled cycles
    assign quiet = still_ff[1] && ocon_ff[11:10] == CPG_MODE_COMP && !ov_both;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff <= 1'b0;
            ap_rd_ff <= 1'b0;
            ap_off_ff <= 8'h00;
        end else if (hready) begin
            ap_wr_ff <= hsel && htrans[1] && hwrite;
            ap_rd_ff <= hsel && htrans[1] && !hwrite;
            ap_off_ff <= haddr[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbcon_ff <= 32'h0;
            ocon_ff <= 32'h0;
            rdt_ff <= 16'h0000;
            fdt_ff <= 16'h0000;
        end else if (ap_wr_ff && hready) begin
            if (ap_off_ff == CPG_TBCON_OFF) tbcon_ff <= hwdata;
            if (ap_off_ff == CPG_OCON_OFF) ocon_ff <= hwdata;
            if (ap_off_ff == CPG_DT_OFF) rdt_ff <= hwdata[15:0];
            if (ap_off_ff == CPG_ALTDT_OFF) fdt_ff <= hwdata[15:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            still_ff <= 2'h0;
        end else if (ap_wr_ff) begin
            still_ff <= 2'h0;
        end else if (still_ff != 2'h3) begin
            still_ff <= still_ff + 2'h1;
        end
    end
    // length of the both-off run, so the gap is judged against the dead time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff <= 16'h0000;
        end else if (high_side_out || low_side_out) begin
            gap_ff <= 16'h0000;
        end else if (gap_ff != 16'hFFFF) begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_unmapped_zero: assert property (ap_rd_ff && ap_off_ff > 8'h2B |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_no_overlap: assert property (quiet |-> !(high_side_out && low_side_out))
        else $error("both outputs on");
    a_dead_low: assert property (quiet && $rose(low_side_out)
        |-> !$past(high_side_out) && gap_ff > fdt_ff)
        else $error("low on without gap");
    a_dead_high: assert property (quiet && $rose(high_side_out)
        |-> !$past(low_side_out) && gap_ff > rdt_ff)
        else $error("high on without gap");
    a_idle_off: assert property (still_ff[1] && !tbcon_ff[CPG_EN_BIT] && ocon_ff[9:8] == 2'h0
        |-> !high_side_out && !low_side_out)
        else $error("output while disabled");
    a_ovr_value: assert property (still_ff[1] && ov_both && !ocon_ff[CPG_OVERRIDE_SYNC_SELECT_BIT]
        |-> {high_side_out, low_side_out} == ocon_ff[7:6])
        else $error("override value not driven");
    a_reset_idle: assert property ($rose(hresetn) |-> !high_side_out && !low_side_out)
        else $error("output after reset");
endmodule
bind cpg_pwm_top cpg_pwm_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cur_reset_in(cur_reset_in), .high_side_out(high_side_out),
    .low_side_out(low_side_out));

//--- testbench/tb_complementary_pwm_generator.sv
// self-checking bench for the pwm generator
`timescale 1ns/1ps
`define CPG_CHK(nm, seen, exp) begin checked++; if ((seen) !== (exp)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, seen); end end
module tb_complementary_pwm_generator import cpg_pkg::*;;
    typedef struct {string nm; logic [31:0] v; logic [31:0] m;} cpg_note_t;
    localparam logic [31:0] OUT_M = 32'h00030000;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cur_reset_in, fire, dp_rd;
    logic high_side_out, low_side_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [1:0] v;
    logic [15:0] dv;
    logic [15:0] dts [7] = '{16'h3, 16'h3, 16'h0, 16'h0, 16'h0, 16'h3, 16'h3};
    logic [15:0] dus [7] = '{16'h0, 16'h14, 16'h0, 16'h15, 16'h16, 16'h0, 16'h14};
    logic [31:0] ctrs [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h4, 32'h4};
    logic [1:0] exs [7] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
    cpg_note_t q[$];
    cpg_note_t note;
    int err_total = 0;
    int checked = 0;
    int i;
    assign hready = hreadyout;
    cpg_pwm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cur_reset_in(cur_reset_in),
        .high_side_out(high_side_out), .low_side_out(low_side_out));
    cpg_stage_model stage (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .cur_reset_in(cur_reset_in));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // read data is judged where the data phase ends, oldest note first
    always @(posedge hclk) begin
        if (dp_rd === 1'b1 && hready === 1'b1) begin
            note = q.pop_front();
            `CPG_CHK(note.nm, hrdata & note.m, note.v)
        end
        dp_rd <= hresetn && hsel && htrans[1] && !hwrite && hready;
    end
    task automatic wait_ready();
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask
    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, off};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask
    task automatic wr(input logic [7:0] off, input logic [31:0] wd);
        bus(1'b1, off, wd);
    endtask
    task automatic rd(input logic [7:0] off, input logic [31:0] e, input logic [31:0] m,
            input string nm);
        cpg_note_t n;
        n.nm = nm;
        n.v = e;
        n.m = m;
        q.push_back(n);
        bus(1'b0, off, 32'h0);
    endtask
    task automatic outs(input logic [1:0] lh, input string nm);
        repeat (7) @(posedge hclk);
        rd(CPG_STAT_OFF, {14'h0, lh, 16'h0}, OUT_M, nm);
    endtask
    task automatic pulse();
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        err_total++;
        finish_test();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fire = 1'b0;
        void'($urandom(80525));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(CPG_TBCON_OFF, 32'h0, 32'hFFFFFFFF, "time_base_control_reg");
        rd(CPG_MPER_OFF, 32'h0000FFFF, 32'hFFFFFFFF, "master period");
        rd(CPG_PHASE_OFF, 32'h0000FFFF, 32'hFFFFFFFF, "phase_period_reg");
        wr(8'h30, $urandom());
        rd(8'h30, 32'h0, 32'hFFFFFFFF, "unmapped");
        rd(CPG_STAT_OFF, 32'h0, OUT_M, "outputs disabled");
        dv = 16'($urandom());
        wr(CPG_DUTY_OFF, {16'($urandom()), dv});
        rd(CPG_DUTY_OFF, {16'h0, dv}, 32'hFFFFFFFF, "generator_duty_reg");
        for (i = 0; i < 4; i++) begin
            wr(CPG_OCON_OFF, 32'(i) << CPG_MODE_LSB);
            rd(CPG_OCON_OFF, 32'(i) << CPG_MODE_LSB, 32'hFFFFFFFF, "mode");
        end
        wr(CPG_OCON_OFF, 32'h0);
        $display("test registers done");
        wr(CPG_MPER_OFF, 32'h0000000A);
        wr(CPG_GCON_OFF, 32'h00000001);
        wr(CPG_TBCON_OFF, 32'h1 << CPG_EN_BIT);
        repeat (200) @(posedge hclk);
        rd(CPG_STAT_OFF, 32'h0, 32'h0000FFF0, "master count");
        wr(CPG_MPER_OFF, 32'h0000FFFF);
        wr(CPG_PHASE_OFF, 32'h0000000A);
        wr(CPG_GCON_OFF, 32'h00000201);
        repeat (200) @(posedge hclk);
        rd(CPG_STAT_OFF, 32'h0, 32'h0000FFF0, "independent count");
        wr(CPG_MPER_OFF, 32'h00004000);
        wr(CPG_GCON_OFF, 32'h00000003);
        // every event must restart, so each pulse follows 100 to 300 idle cycles
        for (i = 0; i < 3; i++) begin
            repeat (100 + $urandom_range(200)) @(posedge hclk);
            pulse();
            rd(CPG_STAT_OFF, 32'h0, 32'h0000FFC0, "count after reset");
        end
        // code 111 acts as 110: one count per 64 clocks, so a fresh restart reads 0 or 1
        wr(CPG_TBDIV_OFF, 32'h7);
        rd(CPG_TBDIV_OFF, 32'h7, 32'hFFFFFFFF, "time_base_divider_reg");
        pulse();
        rd(CPG_STAT_OFF, 32'h0, 32'h0000FFFE, "divided count");
        wr(CPG_TBDIV_OFF, 32'h0);
        $display("test time base done");
        wr(CPG_PHASE_OFF, 32'h00000014);
        for (i = 0; i < 7; i++) begin
            wr(CPG_DT_OFF, {16'h0, dts[i]});
            wr(CPG_ALTDT_OFF, {16'h0, dts[i]});
            wr(CPG_GCON_OFF, 32'h00000201 | ctrs[i]);
            wr(CPG_DUTY_OFF, {16'h0, dus[i]});
            repeat (3) outs(exs[i], "steady duty");
        end
        $display("test duty limits done");
        wr(CPG_MPER_OFF, 32'h00000800);
        wr(CPG_GCON_OFF, 32'h00000002);
        wr(CPG_DUTY_OFF, 32'h0);
        repeat (4300) @(posedge hclk);
        pulse();
        wr(CPG_DUTY_OFF, 32'h00000800);
        outs(2'h2, "duty held");
        wr(CPG_GCON_OFF, 32'h00000003);
        outs(2'h1, "immediate duty");
        wr(CPG_MDUTY_OFF, 32'h0);
        wr(CPG_GCON_OFF, 32'h00000103);
        outs(2'h2, "master duty");
        // synced override waits for the boundary, which the restart put far away
        wr(CPG_OCON_OFF, 32'h00000381);
        outs(2'h2, "override held");
        repeat (2100) @(posedge hclk);
        outs(2'h1, "override at boundary");
        wr(CPG_OCON_OFF, 32'h0);
        $display("test update done");
        wr(CPG_GCON_OFF, 32'h00000201);
        wr(CPG_DUTY_OFF, 32'h4 + $urandom_range(12));
        for (i = 1; i < 3; i++) begin
            v = 2'(i);
            wr(CPG_OCON_OFF, 32'h00000300 | 32'(v) << CPG_OVAL_LSB);
            outs({v[0], v[1]}, "override");
            wr(CPG_OCON_OFF, 32'h0);
            repeat (60) @(posedge hclk);
        end
        for (i = 0; i < 4; i++) begin
            wr(CPG_DUTY_OFF, 32'h4 + $urandom_range(12));
            repeat (15) @(posedge hclk);
        end
        wr(CPG_MPER_OFF, 32'h00000020);
        wr(CPG_GCON_OFF, 32'h0);
        wr(CPG_PHASE_OFF, 32'h00000001);
        repeat (100) @(posedge hclk);
        $display("test override done");
        finish_test();
    end
endmodule
